// ===== rtl/mode_seq_pkg.sv
// Constants, state codes and register layout of the operating-mode sequencer.
// Assumes a 20 MHz core clock and a byte-wide register port behind the serial interface.
// What this block does
// - Writing FFH to the soft reset register at 0DH returns every register to its default.
// - While power-on reset is asserted all registers sit at default, then standby follows.
// - The device enable bit reads zero after power-on reset.
// - Standby with everything off holds whenever the enable bit or the enable pin is low.
// - In standby, register writes are taken only while the enable pin is high.
// - Control bits written outside normal operation are stored but act only after startup.
// - Enable bit and enable pin both high start the startup sequence that powers the core blocks.
// - Startup takes 1 ms when it follows a rise of the enable pin.
// - Startup takes 500 us when it follows the enable bit being written to one with no pin rise since the last startup or soft reset.
// - While overtemperature shutdown is active the device stays in startup.
// - In normal operation a low enable pin clears the enable bit.
// - Power save turns the analog blocks off and keeps all register contents except the enable bit, which a low enable pin clears.
package mode_seq_pkg;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'h0,
    ST_STARTUP = 3'h1,
    ST_NORMAL = 3'h3,
    ST_POWER_SAVE = 3'h2
  } mode_state_t;

  localparam logic [7:0] ENABLE_OFFSET = 8'h00;
  localparam logic [7:0] CONFIG_OFFSET = 8'h08;
  localparam logic [7:0] SOFT_RESET_OFFSET = 8'h0D;
  localparam logic [7:0] SOFT_RESET_KEY = 8'hFF;

  localparam int CHIP_EN_BIT = 6;
  localparam int LOG_EN_BIT = 7;

  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  localparam int CLK_KHZ = 20000;
  localparam int STARTUP_PIN_US = 1000;
  localparam int STARTUP_BIT_US = 500;
  localparam int STARTUP_PIN_CYCLES = (STARTUP_PIN_US * CLK_KHZ) / 1000;
  localparam int STARTUP_BIT_CYCLES = (STARTUP_BIT_US * CLK_KHZ) / 1000;
  localparam int TIMER_W = 16;

endpackage

// ===== rtl/pin_sync.sv
// Two-stage synchroniser for a group of level inputs.
// Assumes inputs are slow levels from pins or other circuits outside the clock.
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Levels.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_s_t;

  sync_s_t q;
  sync_s_t d;

  always_comb
  begin
    d = q;
    d.s1 = async_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign sync_out = q.s2;

endmodule

// ===== rtl/startup_timer.sv
// Down counter that times the startup delay and holds done until restarted.
// Assumes load is at least one and start is a one-cycle pulse.
`timescale 1ns/1ns
module startup_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Control.
  input wire logic start,
  input wire logic [WIDTH-1:0] load,
  output logic done
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic run;
    logic done;
  } timer_s_t;

  timer_s_t q;
  timer_s_t d;

  always_comb
  begin
    d = q;
    if (start)
    begin
      d.cnt = load;
      d.run = 1'b1;
      d.done = 1'b0;
    end
    else if (q.run)
    begin
      if (q.cnt <= {{(WIDTH-1){1'b0}}, 1'b1})
      begin
        d.run = 1'b0;
        d.done = 1'b1;
      end
      else
      begin
        d.cnt = q.cnt - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign done = q.done;

  a_timer_finish: assert property (@(posedge clk) disable iff (!resetn)
    (q.run && !start && q.cnt == {{(WIDTH-1){1'b0}}, 1'b1}) |=> done)
    else $error("timer did not finish on last count");

endmodule

// ===== rtl/power_mode_sequencer.sv
// Operating-mode sequencer: standby, startup, normal and power save with a byte register port.
// Assumes resetn is the power-on reset and the register port comes from the serial front end.
`timescale 1ns/1ns
module power_mode_sequencer #(
  parameter int STARTUP_PIN_CYCLES = mode_seq_pkg::STARTUP_PIN_CYCLES,
  parameter int STARTUP_BIT_CYCLES = mode_seq_pkg::STARTUP_BIT_CYCLES
) (
  // Clock and power-on reset.
  input wire logic clk,
  input wire logic resetn,
  // Pins and monitors.
  input wire logic enable_pin,
  input wire logic overtemp_shutdown,
  input wire logic leds_idle,
  // Register write port.
  input wire logic wr_valid,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Register read port.
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  // Mode outputs.
  output mode_seq_pkg::mode_state_t mode_state,
  output logic analog_on,
  output logic circuits_on,
  output logic chip_en,
  output logic [7:0] enable_active,
  output logic [7:0] config_active
);

  localparam int TW = mode_seq_pkg::TIMER_W;

  typedef struct packed {
    mode_seq_pkg::mode_state_t st;
    logic [7:0] enable;
    logic [7:0] config_r;
    logic [7:0] enable_act;
    logic [7:0] config_act;
    logic en_prev;
    logic pin_fresh;
    logic [7:0] rd_data;
  } seq_s_t;

  localparam seq_s_t Q_RESET = '{
    st: mode_seq_pkg::ST_STANDBY,
    enable: mode_seq_pkg::ENABLE_RESET,
    config_r: mode_seq_pkg::CONFIG_RESET,
    enable_act: mode_seq_pkg::ENABLE_RESET,
    config_act: mode_seq_pkg::CONFIG_RESET,
    en_prev: 1'b0,
    pin_fresh: 1'b0,
    rd_data: 8'h00
  };

  seq_s_t q;
  seq_s_t d;
  logic [1:0] sync_bits;
  logic en_s;
  logic ot_s;
  logic wr_ok;
  logic soft_rst;
  logic timer_start;
  logic [TW-1:0] timer_load;
  logic timer_done;
  logic run_ok;
  logic pin_rise;

  pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({overtemp_shutdown, enable_pin}),
    .sync_out(sync_bits)
  );

  assign en_s = sync_bits[0];
  assign ot_s = sync_bits[1];

  startup_timer #(
    .WIDTH(TW)
  ) u_timer (
    .clk(clk),
    .resetn(resetn),
    .start(timer_start),
    .load(timer_load),
    .done(timer_done)
  );

  assign wr_ok = wr_valid && en_s;
  assign soft_rst = wr_ok && wr_addr == mode_seq_pkg::SOFT_RESET_OFFSET
    && wr_data == mode_seq_pkg::SOFT_RESET_KEY;

  assign pin_rise = en_s && !q.en_prev;

  always_comb
  begin
    d = q;
    timer_start = 1'b0;
    timer_load = (q.pin_fresh || pin_rise) ? TW'(STARTUP_PIN_CYCLES)
      : TW'(STARTUP_BIT_CYCLES);
    run_ok = 1'b0;
    d.en_prev = en_s;
    if (pin_rise)
    begin
      d.pin_fresh = 1'b1;
    end
    if (soft_rst)
    begin
      d = Q_RESET;
      d.en_prev = en_s;
    end
    else
    begin
      if (wr_ok && wr_addr == mode_seq_pkg::ENABLE_OFFSET)
      begin
        d.enable = wr_data;
      end
      else if (wr_ok && wr_addr == mode_seq_pkg::CONFIG_OFFSET)
      begin
        d.config_r = wr_data;
      end
      if (!en_s && (q.st == mode_seq_pkg::ST_NORMAL || q.st == mode_seq_pkg::ST_POWER_SAVE))
      begin
        d.enable[mode_seq_pkg::CHIP_EN_BIT] = 1'b0;
      end
      run_ok = en_s && d.enable[mode_seq_pkg::CHIP_EN_BIT];
      case (q.st)
        mode_seq_pkg::ST_STANDBY:
        begin
          if (run_ok)
          begin
            d.st = mode_seq_pkg::ST_STARTUP;
            d.pin_fresh = 1'b0;
            timer_start = 1'b1;
          end
        end
        mode_seq_pkg::ST_STARTUP:
        begin
          if (!run_ok)
          begin
            d.st = mode_seq_pkg::ST_STANDBY;
          end
          else if (timer_done && !ot_s)
          begin
            d.st = mode_seq_pkg::ST_NORMAL;
            d.enable_act = d.enable;
            d.config_act = d.config_r;
          end
        end
        mode_seq_pkg::ST_NORMAL:
        begin
          d.enable_act = d.enable;
          d.config_act = d.config_r;
          if (!run_ok)
          begin
            d.st = mode_seq_pkg::ST_STANDBY;
          end
          else if (ot_s)
          begin
            d.st = mode_seq_pkg::ST_STARTUP;
          end
          else if (leds_idle)
          begin
            d.st = mode_seq_pkg::ST_POWER_SAVE;
          end
        end
        mode_seq_pkg::ST_POWER_SAVE:
        begin
          if (!run_ok)
          begin
            d.st = mode_seq_pkg::ST_STANDBY;
          end
          else if (ot_s)
          begin
            d.st = mode_seq_pkg::ST_STARTUP;
          end
          else if (!leds_idle)
          begin
            d.st = mode_seq_pkg::ST_NORMAL;
          end
        end
        default:
        begin
          d.st = mode_seq_pkg::ST_STANDBY;
        end
      endcase
    end
    if (rd_addr == mode_seq_pkg::ENABLE_OFFSET)
    begin
      d.rd_data = q.enable;
    end
    else if (rd_addr == mode_seq_pkg::CONFIG_OFFSET)
    begin
      d.rd_data = q.config_r;
    end
    else
    begin
      d.rd_data = 8'h00;
    end
  end

  // Power-on reset holds every register at its default value.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= Q_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign rd_data = q.rd_data;
  assign mode_state = q.st;
  assign analog_on = q.st == mode_seq_pkg::ST_STARTUP || q.st == mode_seq_pkg::ST_NORMAL;
  assign circuits_on = q.st == mode_seq_pkg::ST_NORMAL;
  assign chip_en = q.enable[mode_seq_pkg::CHIP_EN_BIT];
  assign enable_active = q.enable_act;
  assign config_active = q.config_act;

  a_soft_reset_defaults: assert property (@(posedge clk) disable iff (!resetn)
    soft_rst |=> (q.enable == mode_seq_pkg::ENABLE_RESET
      && q.config_r == mode_seq_pkg::CONFIG_RESET && q.st == mode_seq_pkg::ST_STANDBY))
    else $error("soft reset did not restore defaults");

  a_standby_pin_low: assert property (@(posedge clk) disable iff (!resetn)
    !en_s |=> q.st == mode_seq_pkg::ST_STANDBY && !analog_on)
    else $error("not in standby with enable pin low");

  a_write_blocked_low: assert property (@(posedge clk) disable iff (!resetn)
    (wr_valid && !en_s) |=> $stable(q.config_r))
    else $error("write taken with enable pin low");

  a_active_held_back: assert property (@(posedge clk) disable iff (!resetn)
    (q.st != mode_seq_pkg::ST_NORMAL && q.st != mode_seq_pkg::ST_STARTUP && !soft_rst)
      |=> $stable(q.config_act))
    else $error("control bits took effect before startup ended");

  a_startup_launch: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == mode_seq_pkg::ST_STANDBY && en_s && wr_ok && !soft_rst
      && wr_addr == mode_seq_pkg::ENABLE_OFFSET && wr_data[mode_seq_pkg::CHIP_EN_BIT])
      |-> timer_start ##1 (q.st == mode_seq_pkg::ST_STARTUP && analog_on))
    else $error("startup not launched");

  a_pin_delay_sel: assert property (@(posedge clk) disable iff (!resetn)
    (timer_start && (q.pin_fresh || $rose(en_s))) |-> timer_load == TW'(STARTUP_PIN_CYCLES))
    else $error("startup after a pin rise did not take the long delay");

  a_startup_delay_sel: assert property (@(posedge clk) disable iff (!resetn)
    (timer_start && !q.pin_fresh && !$rose(en_s)) |-> timer_load == TW'(STARTUP_BIT_CYCLES))
    else $error("startup after an enable write did not take the short delay");

  a_overtemp_hold: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == mode_seq_pkg::ST_STARTUP && ot_s) |=> q.st != mode_seq_pkg::ST_NORMAL)
    else $error("left startup during overtemperature");

  a_chip_en_clear: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == mode_seq_pkg::ST_NORMAL && !en_s) |=> !chip_en)
    else $error("enable bit not cleared on pin low");

  a_save_analog_off: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == mode_seq_pkg::ST_POWER_SAVE && !wr_ok) |-> !analog_on ##1 $stable(q.config_r))
    else $error("power save lost state or kept analog on");

  a_normal_entry: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == mode_seq_pkg::ST_NORMAL && $past(q.st) == mode_seq_pkg::ST_STARTUP)
      |-> $past(timer_done) && !$past(ot_s))
    else $error("normal entered before delay or during overtemperature");

  a_reset_hold_defaults: assert property (@(posedge clk)
    (!resetn ##1 !resetn)
      |-> (q == Q_RESET && !chip_en))
    else $error("registers left their defaults during power-on reset");

  a_enable_held_back: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == mode_seq_pkg::ST_STANDBY && !soft_rst) |=> $stable(q.enable_act))
    else $error("enable bits took effect before startup ended");

  a_normal_copy: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == mode_seq_pkg::ST_NORMAL && $past(q.st) != mode_seq_pkg::ST_POWER_SAVE)
      |-> (q.enable_act == q.enable && q.config_act == q.config_r))
    else $error("normal mode not governed by the control registers");

  a_save_keeps_regs: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == mode_seq_pkg::ST_POWER_SAVE && en_s && !wr_ok) |=> $stable(q.enable))
    else $error("power save lost the enable register");

  c_reach_normal: cover property (@(posedge clk) disable iff (!resetn)
    q.st == mode_seq_pkg::ST_STARTUP ##1 q.st == mode_seq_pkg::ST_NORMAL);

  c_power_save: cover property (@(posedge clk) disable iff (!resetn)
    q.st == mode_seq_pkg::ST_POWER_SAVE);

  c_overtemp_hold: cover property (@(posedge clk) disable iff (!resetn)
    q.st == mode_seq_pkg::ST_STARTUP && ot_s && timer_done);

  c_soft_reset: cover property (@(posedge clk) disable iff (!resetn)
    soft_rst && q.st == mode_seq_pkg::ST_NORMAL);

  c_pin_relaunch: cover property (@(posedge clk) disable iff (!resetn)
    timer_start && pin_rise);

endmodule

// ===== tb/host_model.sv
// Host side model: drives the enable pin and the register write strobe.
// Assumes the sequencer samples writes on the rising clock edge.
`timescale 1ns/1ns
module host_model #(
  parameter int PIN_WAIT = 20
) (
  // Clock.
  input wire logic clk,
  // Pin and write port.
  output logic enable_pin,
  output logic wr_valid,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);
  initial
  begin
    enable_pin = 1'b0;
    wr_valid = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
  end

  // Raises or lowers the pin; after a rise no bus traffic follows for the wait.
  task automatic set_pin(input logic v);
    @(negedge clk);
    enable_pin = v;
    if (v)
    begin
      repeat (PIN_WAIT) @(negedge clk);
    end
  endtask

  // One byte write; idle lines then carry the inverse of the last value.
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_valid = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_valid = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking testbench of the operating-mode sequencer.
// Assumes shortened startup counts of 20 and 10 cycles at a 50 ns clock.
`timescale 1ns/1ns
module testbench;
  localparam int PIN_N = 20;
  localparam int BIT_N = 10;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic overtemp_shutdown = 1'b0;
  logic leds_idle = 1'b0;
  logic [7:0] rd_addr = 8'h00;
  logic enable_pin, wr_valid, analog_on, circuits_on, chip_en;
  logic [7:0] wr_addr, wr_data, rd_data, enable_active, config_active;
  mode_seq_pkg::mode_state_t mode_state;
  int n_errors = 0;
  int comparisons = 0;
  int n;

  always #25 clk = ~clk;

  host_model #(.PIN_WAIT(PIN_N)) host (.clk(clk), .enable_pin(enable_pin),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data));

  power_mode_sequencer #(.STARTUP_PIN_CYCLES(PIN_N), .STARTUP_BIT_CYCLES(BIT_N)) DUT (
    .clk(clk), .resetn(resetn), .enable_pin(enable_pin),
    .overtemp_shutdown(overtemp_shutdown), .leds_idle(leds_idle),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .mode_state(mode_state),
    .analog_on(analog_on), .circuits_on(circuits_on), .chip_en(chip_en),
    .enable_active(enable_active), .config_active(config_active));

  task automatic results();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    chk(rd_data, exp);
  endtask

  task automatic wait_st(input mode_seq_pkg::mode_state_t s, input int lim);
    n = 0;
    while (mode_state !== s)
    begin
      if (n >= lim)
      begin
        $display("[ERR] %0t got %h exp %h", $time, mode_state, s);
        n_errors++;
        results();
      end
      @(negedge clk);
      n++;
    end
    chk({5'h00, mode_state}, {5'h00, s});
  endtask

  task automatic win(input int lo, input int hi);
    comparisons++;
    if (n < lo || n > hi)
    begin
      $display("[ERR] %0t got %h exp %h", $time, n, lo);
      n_errors++;
    end
  endtask

  task automatic t_reset();
    rd(8'h00, 8'h00);
    rd(8'h08, 8'h00);
    chk({7'h00, chip_en}, 8'h00);
    chk({6'h00, analog_on, circuits_on}, 8'h00);
  endtask

  task automatic t_refuse();
    host.write(8'h00, 8'h40);
    rd(8'h00, 8'h00);
    wait_st(mode_seq_pkg::ST_STANDBY, 1);
  endtask

  task automatic t_pin_start();
    host.set_pin(1'b1);
    host.write(8'h08, 8'h5A);
    rd(8'h08, 8'h5A);
    chk(config_active, 8'h00);
    host.write(8'h00, 8'h40);
    chk({6'h00, analog_on, circuits_on}, 8'h02);
    chk(enable_active, 8'h00);
    wait_st(mode_seq_pkg::ST_NORMAL, 40);
    win(PIN_N - 1, PIN_N + 4);
    chk(config_active, 8'h5A);
    chk(enable_active, 8'h40);
    chk({7'h00, circuits_on}, 8'h01);
  endtask

  task automatic t_overtemp();
    @(negedge clk);
    overtemp_shutdown = 1'b1;
    wait_st(mode_seq_pkg::ST_STARTUP, 5);
    repeat (PIN_N) @(negedge clk);
    wait_st(mode_seq_pkg::ST_STARTUP, 0);
    chk({6'h00, analog_on, circuits_on}, 8'h02);
    overtemp_shutdown = 1'b0;
    wait_st(mode_seq_pkg::ST_NORMAL, 5);
  endtask

  task automatic t_save();
    leds_idle = 1'b1;
    wait_st(mode_seq_pkg::ST_POWER_SAVE, 3);
    chk({7'h00, analog_on}, 8'h00);
    rd(8'h08, 8'h5A);
    leds_idle = 1'b0;
    wait_st(mode_seq_pkg::ST_NORMAL, 3);
  endtask

  task automatic t_bit_start();
    host.write(8'h00, 8'h00);
    wait_st(mode_seq_pkg::ST_STANDBY, 3);
    host.write(8'h00, 8'h40);
    wait_st(mode_seq_pkg::ST_NORMAL, 40);
    win(BIT_N - 1, BIT_N + 4);
  endtask

  task automatic t_pin_low();
    host.set_pin(1'b0);
    wait_st(mode_seq_pkg::ST_STANDBY, 4);
    chk({7'h00, chip_en}, 8'h00);
    rd(8'h00, 8'h00);
  endtask

  task automatic t_soft();
    host.set_pin(1'b1);
    host.write(8'h08, 8'h33);
    host.write(8'h0D, 8'hFE);
    rd(8'h08, 8'h33);
    rd(8'h0D, 8'h00);
    host.write(8'h00, 8'h40);
    wait_st(mode_seq_pkg::ST_STARTUP, 1);
    host.write(8'h0D, 8'hFF);
    wait_st(mode_seq_pkg::ST_STANDBY, 2);
    rd(8'h08, 8'h00);
    rd(8'h00, 8'h00);
    chk(config_active, 8'h00);
  endtask

  // Pin drops during startup, then rises again with the enable bit still set.
  task automatic t_relaunch();
    host.write(8'h00, 8'h40);
    wait_st(mode_seq_pkg::ST_STARTUP, 1);
    host.set_pin(1'b0);
    wait_st(mode_seq_pkg::ST_STANDBY, 4);
    chk({7'h00, chip_en}, 8'h01);
    host.set_pin(1'b1);
    wait_st(mode_seq_pkg::ST_NORMAL, 40);
    win(2, 8);
  endtask

  // Power-on reset in the middle of normal operation.
  task automatic t_por();
    chk(enable_active, 8'h40);
    resetn = 1'b0;
    @(negedge clk);
    chk({7'h00, chip_en}, 8'h00);
    chk(enable_active, 8'h00);
    chk({6'h00, analog_on, circuits_on}, 8'h00);
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    wait_st(mode_seq_pkg::ST_STANDBY, 0);
    rd(8'h00, 8'h00);
  endtask

  initial
  begin
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_refuse();
    t_pin_start();
    t_overtemp();
    t_save();
    t_bit_start();
    t_pin_low();
    t_soft();
    t_relaunch();
    t_por();
    results();
  end
endmodule
